// >>> inc/iocfg_pkg.sv
// Constants, field layout and state codes for the IO configuration address/data port.
// Assumes a 16-bit IO byte address space with 32-bit data and per-byte enables.
package iocfg_pkg;

    // Register locations in IO space
    localparam logic [15:0] ADDR_REG_OFS = 16'h0CF8;
    localparam logic [15:0] DATA_PORT_OFS = 16'h0CFC;

    // Reset values
    localparam logic [31:0] ADDR_REG_RESET = 32'h00000000;
    localparam logic [31:0] DATA_PORT_RESET = 32'h00000000;

    // Writable bits of the address register; 30:28 and 1:0 are reserved and read zero
    localparam logic [31:0] ADDR_REG_WMASK = 32'h8FFFFFFC;

    // Field positions of the address register
    localparam int unsigned EN_BIT = 31;
    localparam int unsigned EXT_MSB = 27;
    localparam int unsigned EXT_LSB = 24;
    localparam int unsigned BUS_MSB = 23;
    localparam int unsigned BUS_LSB = 16;
    localparam int unsigned DEV_MSB = 15;
    localparam int unsigned DEV_LSB = 11;
    localparam int unsigned FUNC_MSB = 10;
    localparam int unsigned FUNC_LSB = 8;
    localparam int unsigned REG_MSB = 7;
    localparam int unsigned REG_LSB = 2;

    // Field widths
    localparam int unsigned BUS_W = 8;
    localparam int unsigned DEV_W = 5;
    localparam int unsigned FUNC_W = 3;
    localparam int unsigned CFG_REG_W = 10;

    localparam logic [3:0] BE_FULL = 4'hF;
    localparam logic [3:0] EXT_OFF = 4'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CFG = 2'b01,
        ST_LINK = 2'b10,
        ST_RESP = 2'b11
    } iocfg_state_t;

endpackage

// >>> inc/iocfg_tgt_if.sv
// Carries the address register to the target formatter and the formatted target back.
// Assumes both ends sit on the same clock; the bundle is purely combinational.
`timescale 1ns/1ps
interface iocfg_tgt_if;
    logic [31:0] addr_reg;
    logic ext_en;
    logic [7:0] bus;
    logic [4:0] dev;
    logic [2:0] func;
    logic [9:0] reg_ofs;

    modport fmt (
        input addr_reg,
        input ext_en,
        output bus,
        output dev,
        output func,
        output reg_ofs
    );

    modport user (
        output addr_reg,
        output ext_en,
        input bus,
        input dev,
        input func,
        input reg_ofs
    );
endinterface

// >>> logic/iocfg_cfg_target.sv
// Splits the configuration address register into the target of a configuration cycle.
// Assumes the register value is already masked; purely combinational.
`timescale 1ns/1ps
module iocfg_cfg_target (
    iocfg_tgt_if.fmt tgt
);
    assign tgt.bus = tgt.addr_reg[iocfg_pkg::BUS_MSB:iocfg_pkg::BUS_LSB];
    assign tgt.dev = tgt.addr_reg[iocfg_pkg::DEV_MSB:iocfg_pkg::DEV_LSB];
    assign tgt.func = tgt.addr_reg[iocfg_pkg::FUNC_MSB:iocfg_pkg::FUNC_LSB];
    // Extended bits only count when the extended setting is on; otherwise they are replaced by zero
    assign tgt.reg_ofs = {(tgt.ext_en ? tgt.addr_reg[iocfg_pkg::EXT_MSB:iocfg_pkg::EXT_LSB] : iocfg_pkg::EXT_OFF),
                          tgt.addr_reg[iocfg_pkg::REG_MSB:iocfg_pkg::REG_LSB]};
endmodule

// >>> logic/iocfg_range_match.sv
// Compares an IO address against the programmed base/limit ranges and picks a link.
// Assumes ranges come from registers on the same clock; lowest matching entry wins.
`timescale 1ns/1ps
module iocfg_range_match #(
    parameter int unsigned NUM_RANGES = 4,
    parameter int unsigned LINK_W = 2
) (
    input wire logic [15:0] addr,
    input wire logic [NUM_RANGES*16-1:0] base,
    input wire logic [NUM_RANGES*16-1:0] limit,
    input wire logic [NUM_RANGES-1:0] en,
    input wire logic [NUM_RANGES*LINK_W-1:0] dst,
    output logic hit,
    output logic [LINK_W-1:0] link
);
    logic [NUM_RANGES-1:0] in_range;

    genvar g;
    generate
        for (g = 0; g < NUM_RANGES; g++) begin : g_range
            assign in_range[g] = en[g] && (addr >= base[g*16 +: 16]) && (addr <= limit[g*16 +: 16]);
        end
    endgenerate

    always_comb begin
        hit = 1'b0;
        link = '0;
        for (int i = NUM_RANGES - 1; i >= 0; i--) begin
            if (in_range[i]) begin
                hit = 1'b1;
                link = dst[i*LINK_W +: LINK_W];
            end
        end
    end
endmodule

// >>> logic/iocfg_port.sv
// IO configuration address/data port: turns IO accesses into configuration cycles or forwards them.
// Assumes the processor IO side, link side and configuration side all run on SYS_CLK.
`timescale 1ns/1ps
module iocfg_port #(
    parameter int unsigned NUM_RANGES = 4,
    parameter int unsigned LINK_W = 2,
    parameter logic [1:0] DEFAULT_LINK = 2'h0
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    // Processor IO request
    input wire logic IO_REQ_VALID,
    output logic IO_REQ_READY,
    input wire logic IO_REQ_WRITE,
    input wire logic [15:0] IO_REQ_ADDR,
    input wire logic [3:0] IO_REQ_BE,
    input wire logic [31:0] IO_REQ_WDATA,
    input wire logic IO_REQ_FROM_LINK,
    output logic IO_RSP_VALID,
    output logic [31:0] IO_RSP_RDATA,
    // Extended configuration setting and IO base/limit ranges
    input wire logic EXT_CFG_ENABLE,
    input wire logic [NUM_RANGES*16-1:0] IO_RANGE_BASE,
    input wire logic [NUM_RANGES*16-1:0] IO_RANGE_LIMIT,
    input wire logic [NUM_RANGES-1:0] IO_RANGE_EN,
    input wire logic [NUM_RANGES*LINK_W-1:0] IO_RANGE_LINK,
    // Forwarded IO towards a link
    output logic LINK_REQ_VALID,
    output logic LINK_REQ_WRITE,
    output logic [15:0] LINK_REQ_ADDR,
    output logic [3:0] LINK_REQ_BE,
    output logic [31:0] LINK_REQ_WDATA,
    output logic [LINK_W-1:0] LINK_REQ_DEST,
    input wire logic LINK_RSP_VALID,
    input wire logic [31:0] LINK_RSP_RDATA,
    // Configuration space access
    output logic CFG_REQ_VALID,
    output logic CFG_REQ_WRITE,
    output logic [7:0] CFG_BUS,
    output logic [4:0] CFG_DEV,
    output logic [2:0] CFG_FUNC,
    output logic [9:0] CFG_REG,
    output logic [3:0] CFG_BE,
    output logic [31:0] CFG_WDATA,
    input wire logic CFG_RSP_VALID,
    input wire logic [31:0] CFG_RSP_RDATA
);
    iocfg_pkg::iocfg_state_t state;
    iocfg_pkg::iocfg_state_t next_state;

    logic [31:0] addr_reg;
    logic [31:0] data_port;
    logic req_write;

    logic take;
    logic is_addr_loc;
    logic is_data_loc;
    logic aligned_dw;
    logic do_reg;
    logic do_cfg;
    logic do_link;
    logic range_hit;
    logic [LINK_W-1:0] range_link;
    logic [31:0] merged_wdata;

    iocfg_tgt_if tgt ();

    assign tgt.addr_reg = addr_reg;
    assign tgt.ext_en = EXT_CFG_ENABLE;

    iocfg_cfg_target u_target (
        .tgt(tgt)
    );

    iocfg_range_match #(
        .NUM_RANGES(NUM_RANGES),
        .LINK_W(LINK_W)
    ) u_range (
        .addr(IO_REQ_ADDR),
        .base(IO_RANGE_BASE),
        .limit(IO_RANGE_LIMIT),
        .en(IO_RANGE_EN),
        .dst(IO_RANGE_LINK),
        .hit(range_hit),
        .link(range_link)
    );

    // Classification of the request on offer
    assign take = IO_REQ_VALID && IO_REQ_READY;
    assign is_addr_loc = IO_REQ_ADDR[15:2] == iocfg_pkg::ADDR_REG_OFS[15:2];
    assign is_data_loc = IO_REQ_ADDR[15:2] == iocfg_pkg::DATA_PORT_OFS[15:2];
    assign aligned_dw = (IO_REQ_ADDR[1:0] == 2'h0) && (IO_REQ_BE == iocfg_pkg::BE_FULL);
    // Link-sourced traffic is kept away from both local locations
    assign do_reg = !IO_REQ_FROM_LINK && is_addr_loc && aligned_dw;
    assign do_cfg = !IO_REQ_FROM_LINK && is_data_loc && addr_reg[iocfg_pkg::EN_BIT];
    assign do_link = !do_reg && !do_cfg;

    // Byte-lane merge of a data port write into the held data
    always_comb begin
        merged_wdata = data_port;
        for (int b = 0; b < 4; b++) begin
            if (IO_REQ_BE[b]) begin
                merged_wdata[b*8 +: 8] = IO_REQ_WDATA[b*8 +: 8];
            end
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            iocfg_pkg::ST_IDLE: begin
                if (take) begin
                    if (do_reg) begin
                        next_state = iocfg_pkg::ST_RESP;
                    end else if (do_cfg) begin
                        next_state = iocfg_pkg::ST_CFG;
                    end else begin
                        next_state = iocfg_pkg::ST_LINK;
                    end
                end
            end
            iocfg_pkg::ST_CFG: begin
                if (CFG_RSP_VALID) begin
                    next_state = iocfg_pkg::ST_RESP;
                end
            end
            iocfg_pkg::ST_LINK: begin
                if (LINK_RSP_VALID) begin
                    next_state = iocfg_pkg::ST_RESP;
                end
            end
            iocfg_pkg::ST_RESP: begin
                next_state = iocfg_pkg::ST_IDLE;
            end
            default: begin
                next_state = iocfg_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state <= iocfg_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // One request at a time: ready only while idle and nothing is pending
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            IO_REQ_READY <= 1'b0;
        end else begin
            IO_REQ_READY <= (next_state == iocfg_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            req_write <= 1'b0;
        end else if (take) begin
            req_write <= IO_REQ_WRITE;
        end
    end

    // Address register; reserved bits never store
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            addr_reg <= iocfg_pkg::ADDR_REG_RESET;
        end else if (take && do_reg && IO_REQ_WRITE) begin
            addr_reg <= IO_REQ_WDATA & iocfg_pkg::ADDR_REG_WMASK;
        end
    end

    // Data port holds the last translated write or the last completed translated read
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            data_port <= iocfg_pkg::DATA_PORT_RESET;
        end else if (take && do_cfg && IO_REQ_WRITE) begin
            data_port <= merged_wdata;
        end else if (state == iocfg_pkg::ST_CFG && CFG_RSP_VALID && !req_write) begin
            data_port <= CFG_RSP_RDATA;
        end
    end

    // Configuration request: one pulse per translated access, target frozen at take time
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            CFG_REQ_VALID <= 1'b0;
        end else begin
            CFG_REQ_VALID <= take && do_cfg;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            CFG_BUS <= '0;
            CFG_DEV <= '0;
            CFG_FUNC <= '0;
            CFG_REG <= '0;
        end else if (take && do_cfg) begin
            CFG_BUS <= tgt.bus;
            CFG_DEV <= tgt.dev;
            CFG_FUNC <= tgt.func;
            CFG_REG <= tgt.reg_ofs;
        end
    end

    // Lanes outside the enables carry the held data port value, so the target never sees stale bus data
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            CFG_REQ_WRITE <= 1'b0;
            CFG_BE <= '0;
            CFG_WDATA <= '0;
        end else if (take && do_cfg) begin
            CFG_REQ_WRITE <= IO_REQ_WRITE;
            CFG_BE <= IO_REQ_BE;
            CFG_WDATA <= merged_wdata;
        end
    end

    // Forwarding towards a link; unmatched addresses fall back to the default link
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            LINK_REQ_VALID <= 1'b0;
        end else begin
            LINK_REQ_VALID <= take && do_link;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            LINK_REQ_DEST <= '0;
        end else if (take && do_link) begin
            LINK_REQ_DEST <= range_hit ? range_link : DEFAULT_LINK[LINK_W-1:0];
        end
    end

    // Payload is a plain copy; the link does its own byte-lane handling
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            LINK_REQ_WRITE <= 1'b0;
            LINK_REQ_ADDR <= '0;
            LINK_REQ_BE <= '0;
            LINK_REQ_WDATA <= '0;
        end else if (take && do_link) begin
            LINK_REQ_WRITE <= IO_REQ_WRITE;
            LINK_REQ_ADDR <= IO_REQ_ADDR;
            LINK_REQ_BE <= IO_REQ_BE;
            LINK_REQ_WDATA <= IO_REQ_WDATA;
        end
    end

    // Answer to the processor; writes answer with zero data
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            IO_RSP_VALID <= 1'b0;
        end else begin
            IO_RSP_VALID <= (next_state == iocfg_pkg::ST_RESP);
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            IO_RSP_RDATA <= '0;
        end else begin
            case (state)
                iocfg_pkg::ST_IDLE: begin
                    if (take && do_reg) begin
                        IO_RSP_RDATA <= IO_REQ_WRITE ? 32'h00000000 : addr_reg;
                    end
                end
                iocfg_pkg::ST_CFG: begin
                    if (CFG_RSP_VALID) begin
                        IO_RSP_RDATA <= req_write ? 32'h00000000 : CFG_RSP_RDATA;
                    end
                end
                iocfg_pkg::ST_LINK: begin
                    if (LINK_RSP_VALID) begin
                        IO_RSP_RDATA <= req_write ? 32'h00000000 : LINK_RSP_RDATA;
                    end
                end
                default: begin
                    IO_RSP_RDATA <= IO_RSP_RDATA;
                end
            endcase
        end
    end
endmodule

// >>> bench/iocfg_chk_asserts.sv
// Checker for the IO configuration port: watches the top module's ports only.
// Assumes one clock domain, SYS_CLK, with RST asynchronous and active high.
`timescale 1ns/1ps
module iocfg_chk (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic IO_REQ_VALID,
    input wire logic IO_REQ_READY,
    input wire logic IO_REQ_WRITE,
    input wire logic [15:0] IO_REQ_ADDR,
    input wire logic [3:0] IO_REQ_BE,
    input wire logic [31:0] IO_REQ_WDATA,
    input wire logic IO_REQ_FROM_LINK,
    input wire logic IO_RSP_VALID,
    input wire logic [31:0] IO_RSP_RDATA,
    input wire logic EXT_CFG_ENABLE,
    input wire logic LINK_REQ_VALID,
    input wire logic [15:0] LINK_REQ_ADDR,
    input wire logic CFG_REQ_VALID,
    input wire logic CFG_REQ_WRITE,
    input wire logic [7:0] CFG_BUS,
    input wire logic [4:0] CFG_DEV,
    input wire logic [2:0] CFG_FUNC,
    input wire logic [9:0] CFG_REG
);
    logic [31:0] areg;
    wire take = IO_REQ_VALID && IO_REQ_READY;
    wire loc_cf8 = take && !IO_REQ_FROM_LINK && IO_REQ_ADDR == 16'h0CF8 && IO_REQ_BE == 4'hF;
    wire loc_cfc = take && !IO_REQ_FROM_LINK && IO_REQ_ADDR[15:2] == 14'h033F;
    // Shadow of the address register, so field checks need no view inside
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            areg <= 32'h00000000;
        end else if (loc_cf8 && IO_REQ_WRITE) begin
            areg <= IO_REQ_WDATA & iocfg_pkg::ADDR_REG_WMASK;
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    a_reg_local: assert property (loc_cf8 |=> IO_RSP_VALID && !LINK_REQ_VALID && !CFG_REQ_VALID)
        else $error("address register access left the block");
    a_reg_read: assert property (loc_cf8 && !IO_REQ_WRITE |=> IO_RSP_RDATA == $past(areg))
        else $error("address register read data wrong");
    a_link_only: assert property (take && IO_REQ_FROM_LINK |=> LINK_REQ_VALID && !CFG_REQ_VALID)
        else $error("link access not forwarded");
    a_link_addr: assert property (take && IO_REQ_FROM_LINK |=> LINK_REQ_ADDR == $past(IO_REQ_ADDR))
        else $error("forwarded address wrong");
    a_off_fwd: assert property (loc_cfc && !areg[31] |=> LINK_REQ_VALID && !CFG_REQ_VALID)
        else $error("disabled data port not forwarded");
    a_on_cfg: assert property (loc_cfc && areg[31] |=> CFG_REQ_VALID
        && CFG_REQ_WRITE == $past(IO_REQ_WRITE) && CFG_BUS == areg[23:16] && CFG_DEV == areg[15:11]
        && CFG_FUNC == areg[10:8])
        else $error("configuration cycle target wrong");
    a_cfg_reg: assert property (loc_cfc && areg[31] |=>
        CFG_REG == {($past(EXT_CFG_ENABLE) ? areg[27:24] : 4'h0), areg[7:2]})
        else $error("configuration register offset wrong");
    a_take_busy: assert property (take |=> !IO_REQ_READY)
        else $error("second request accepted while one is pending");
    a_one_cfg: assert property (CFG_REQ_VALID |=> !CFG_REQ_VALID [*2])
        else $error("more than one configuration access");
endmodule
bind iocfg_port iocfg_chk u_iocfg_chk (.SYS_CLK(SYS_CLK), .RST(RST), .IO_REQ_VALID(IO_REQ_VALID),
    .IO_REQ_READY(IO_REQ_READY), .IO_REQ_WRITE(IO_REQ_WRITE), .IO_REQ_ADDR(IO_REQ_ADDR), .IO_REQ_BE(IO_REQ_BE),
    .IO_REQ_WDATA(IO_REQ_WDATA), .IO_REQ_FROM_LINK(IO_REQ_FROM_LINK), .IO_RSP_VALID(IO_RSP_VALID),
    .IO_RSP_RDATA(IO_RSP_RDATA), .EXT_CFG_ENABLE(EXT_CFG_ENABLE), .LINK_REQ_VALID(LINK_REQ_VALID),
    .LINK_REQ_ADDR(LINK_REQ_ADDR), .CFG_REQ_VALID(CFG_REQ_VALID), .CFG_REQ_WRITE(CFG_REQ_WRITE),
    .CFG_BUS(CFG_BUS), .CFG_DEV(CFG_DEV), .CFG_FUNC(CFG_FUNC), .CFG_REG(CFG_REG));

// >>> bench/iocfg_far_model.sv
// Far side model: configuration space storage and an IO link, answering after a set delay.
// Assumes one request at a time; response data wanders outside the completion pulse.
`timescale 1ns/1ps
module iocfg_far_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] delay,
    input wire logic cfg_req_valid,
    input wire logic cfg_req_write,
    input wire logic [9:0] cfg_reg,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_rsp_valid,
    output logic [31:0] cfg_rsp_rdata,
    input wire logic link_req_valid,
    input wire logic [15:0] link_req_addr,
    output logic link_rsp_valid,
    output logic [31:0] link_rsp_rdata
);
    logic [31:0] mem [0:1023];
    logic [3:0] cnt;
    logic busy;
    logic is_cfg;
    logic [15:0] ad;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            is_cfg <= 1'b0;
            ad <= 16'h0000;
            cfg_rsp_valid <= 1'b0;
            link_rsp_valid <= 1'b0;
            cfg_rsp_rdata <= 32'h00000000;
            link_rsp_rdata <= 32'h00000000;
        end else begin
            cfg_rsp_valid <= 1'b0;
            link_rsp_valid <= 1'b0;
            // Stale data is inverted so no read can pass by luck
            cfg_rsp_rdata <= ~cfg_rsp_rdata;
            link_rsp_rdata <= ~link_rsp_rdata;
            if (cfg_req_valid || link_req_valid) begin
                busy <= 1'b1;
                cnt <= delay;
                is_cfg <= cfg_req_valid;
                ad <= cfg_req_valid ? {6'h00, cfg_reg} : link_req_addr;
                if (cfg_req_valid && cfg_req_write) begin
                    mem[cfg_reg] <= cfg_wdata;
                end
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                if (is_cfg) begin
                    cfg_rsp_valid <= 1'b1;
                    cfg_rsp_rdata <= mem[ad[9:0]];
                end else begin
                    link_rsp_valid <= 1'b1;
                    link_rsp_rdata <= {16'h5A5A, ad};
                end
            end
        end
    end
endmodule

// >>> bench/tb.sv
// Self-checking bench for the IO configuration port with the far side model.
// Assumes a 100 ns clock and a single outstanding IO request.
`timescale 1ns/1ps
module tb;
    logic clk, rst, vld, wr, fl, ext;
    logic [15:0] ad;
    logic [3:0] be, dly, ren;
    logic [31:0] wd, got;
    logic [63:0] rb, rl;
    logic [7:0] rk;
    wire rdy, rv, lv, lw, cv, cw, crv, lrv;
    wire [31:0] rd, lwd, cwd, crd, lrd;
    wire [15:0] la;
    wire [3:0] lbe, cbe;
    wire [1:0] ldst;
    wire [7:0] cbus;
    wire [4:0] cdev;
    wire [2:0] cfn;
    wire [9:0] creg;
    int bad_count, checked, ncfg, nlink, n0;
    iocfg_port u_iocfg_port (.SYS_CLK(clk), .RST(rst), .IO_REQ_VALID(vld), .IO_REQ_READY(rdy), .IO_REQ_WRITE(wr),
        .IO_REQ_ADDR(ad), .IO_REQ_BE(be), .IO_REQ_WDATA(wd), .IO_REQ_FROM_LINK(fl), .IO_RSP_VALID(rv),
        .IO_RSP_RDATA(rd), .EXT_CFG_ENABLE(ext), .IO_RANGE_BASE(rb), .IO_RANGE_LIMIT(rl), .IO_RANGE_EN(ren),
        .IO_RANGE_LINK(rk), .LINK_REQ_VALID(lv), .LINK_REQ_WRITE(lw), .LINK_REQ_ADDR(la), .LINK_REQ_BE(lbe),
        .LINK_REQ_WDATA(lwd), .LINK_REQ_DEST(ldst), .LINK_RSP_VALID(lrv), .LINK_RSP_RDATA(lrd),
        .CFG_REQ_VALID(cv), .CFG_REQ_WRITE(cw), .CFG_BUS(cbus), .CFG_DEV(cdev), .CFG_FUNC(cfn), .CFG_REG(creg),
        .CFG_BE(cbe), .CFG_WDATA(cwd), .CFG_RSP_VALID(crv), .CFG_RSP_RDATA(crd));
    iocfg_far_model u_iocfg_far_model (.clk(clk), .rst(rst), .delay(dly), .cfg_req_valid(cv),
        .cfg_req_write(cw), .cfg_reg(creg), .cfg_wdata(cwd), .cfg_rsp_valid(crv), .cfg_rsp_rdata(crd),
        .link_req_valid(lv), .link_req_addr(la), .link_rsp_valid(lrv), .link_rsp_rdata(lrd));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (cv === 1'b1) ncfg++;
        if (lv === 1'b1) nlink++;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    // One IO transfer; request held until the edge that sees ready
    task automatic io(input logic w, input logic [15:0] a, input logic [3:0] b, input logic [31:0] d, input logic f);
        int n;
        @(posedge clk);
        vld <= 1'b1;
        wr <= w;
        ad <= a;
        be <= b;
        wd <= d;
        fl <= f;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        @(posedge clk);
        vld <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rv !== 1'b1 && n < 50);
        // A missing answer is a mismatch of its own
        if (rv !== 1'b1) begin
            bad_count++;
        end
        got = rd;
    endtask
    task automatic t_reset;
        io(0, 16'h0CF8, 4'hF, 0, 0);
        chk(got, 32'h0);
        n0 = nlink;
        io(0, 16'h0CFC, 4'hF, 0, 0);
        chk(got, 32'h5A5A0CFC);
        chk(ncfg, 0);
        chk(nlink, n0 + 1);
    endtask
    task automatic t_areg;
        io(1, 16'h0CF8, 4'hF, 32'hFFFFFFFF, 0);
        io(0, 16'h0CF8, 4'hF, 0, 0);
        chk(got, 32'h8FFFFFFC);
        n0 = nlink;
        io(1, 16'h0CF8, 4'h3, 32'h0000BEEF, 0);
        chk({11'h0, lw, lbe, la}, {11'h0, 1'b1, 4'h3, 16'h0CF8});
        chk(lwd, 32'h0000BEEF);
        io(1, 16'h0CFA, 4'hF, 0, 0);
        io(0, 16'h0CF8, 4'hF, 0, 0);
        chk(got, 32'h8FFFFFFC);
        chk(nlink, n0 + 2);
    endtask
    task automatic t_link;
        @(posedge clk);
        rb <= 64'h0000_0000_0C00_0000;
        rl <= 64'h0000_0000_0CFF_0000;
        rk <= 8'h08;
        ren <= 4'h2;
        n0 = ncfg;
        io(1, 16'h0CF8, 4'hF, 0, 1);
        chk({30'h0, ldst}, 32'h2);
        io(0, 16'h0CFC, 4'hF, 0, 1);
        chk(ncfg, n0);
        io(0, 16'h0CF8, 4'hF, 0, 0);
        chk(got, 32'h8FFFFFFC);
        @(posedge clk);
        ren <= 4'h0;
        io(0, 16'h0CFC, 4'hF, 0, 1);
        chk({30'h0, ldst}, 32'h0);
    endtask
    task automatic t_cfg(input logic e, input logic [3:0] dl, input logic [31:0] d);
        @(posedge clk);
        ext <= e;
        dly <= dl;
        io(1, 16'h0CF8, 4'hF, 32'h8A5A9DF0, 0);
        n0 = ncfg;
        io(1, 16'h0CFC, 4'hF, d, 0);
        chk(ncfg, n0 + 1);
        chk({16'h0, cbus, cdev, cfn}, {16'h0, 8'h5A, 5'h13, 3'h5});
        chk({22'h0, creg}, {22'h0, (e ? 4'hA : 4'h0), 6'h3C});
        chk(cwd, d);
        chk({28'h0, cbe}, 32'hF);
        io(0, 16'h0CFC, 4'hF, 0, 0);
        chk(got, d);
    endtask
    // Reset in mid-run: the data port must come back as zero, seen through a partial write
    task automatic t_midrst;
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        io(0, 16'h0CF8, 4'hF, 0, 0);
        chk(got, 32'h0);
        io(1, 16'h0CF8, 4'hF, 32'h80000000, 0);
        io(1, 16'h0CFC, 4'h3, 32'hFFFFFFFF, 0);
        chk(cwd, 32'h0000FFFF);
        chk({28'h0, cbe}, 32'h3);
    endtask
    task automatic results;
        if (bad_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #400000;
        bad_count++;
        results();
    end
    initial begin
        rst <= 1'b1;
        vld <= 1'b0;
        wr <= 1'b0;
        fl <= 1'b0;
        ext <= 1'b0;
        ad <= 16'h0;
        be <= 4'h0;
        dly <= 4'h0;
        ren <= 4'h0;
        wd <= 32'h0;
        rb <= 64'h0;
        rl <= 64'h0;
        rk <= 8'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_areg();
        t_link();
        t_cfg(1'b0, 4'h0, 32'h12345678);
        t_cfg(1'b1, 4'h5, 32'hCAFE0001);
        t_midrst();
        results();
    end
endmodule
